// >>> inc/lhcr_pkg.sv
// Constants for the fallback configuration register slice
package lhcr_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_FALLBACK_CONFIG_ONE = 8'h1E;
  localparam logic [7:0] OFS_FALLBACK_CONFIG_TWO = 8'h1F;
  localparam logic [7:0] OFS_EXTERNAL_REF_LOW = 8'h20;
  localparam logic [7:0] OFS_EXTERNAL_REF_HIGH = 8'h21;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_FALLBACK_CONFIG_ONE = 8'h00;
  localparam logic [7:0] RST_FALLBACK_CONFIG_TWO = 8'h00;
  localparam logic [9:0] RST_EXT_REF_CODE = 10'h000;

  // ----------------------------------------------------------------
  // Field positions, fallback_config_one
  // ----------------------------------------------------------------
  localparam int BIT_DIM_PHASE_SEL = 7;
  localparam int BIT_EXT_REF_SEL = 6;
  localparam int BIT_CH2_FULL_DUTY = 5;
  localparam int BIT_CH2_INT_DIM = 4;
  localparam int BIT_CH2_ENABLE = 3;
  localparam int BIT_CH1_FULL_DUTY = 2;
  localparam int BIT_CH1_INT_DIM = 1;
  localparam int BIT_CH1_ENABLE = 0;

  // ----------------------------------------------------------------
  // Field positions, fallback_config_two
  // ----------------------------------------------------------------
  localparam int BIT_TIMER_LIMIT_HI = 7;
  localparam int BIT_TIMER_LIMIT_LO = 6;
  localparam int BIT_CH2_THERMAL_LATCH = 5;
  localparam int BIT_CH2_HS_OC_LATCH = 4;
  localparam int BIT_CH2_LS_OC_LATCH = 3;
  localparam int BIT_CH1_THERMAL_LATCH = 2;
  localparam int BIT_CH1_HS_OC_LATCH = 1;
  localparam int BIT_CH1_LS_OC_LATCH = 0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_FREQ_KHZ = 20000;
  localparam int FAULT_TIMER_BASE_US = 3600;
  localparam int FAULT_TIMER_BASE_CYCLES = FAULT_TIMER_BASE_US * CLK_FREQ_KHZ / 1000;
  localparam int FAULT_TIMER_WIDTH = 20;

  // Half period offset of the 10-bit dimming counter
  localparam logic [9:0] DIM_HALF_PERIOD = 10'h200;

  // ----------------------------------------------------------------
  // Fault recovery state per channel
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FLT_RUN = 2'b00,
    FLT_THERMAL = 2'b01,
    FLT_TIMER = 2'b10
  } lhcr_fault_e;

endpackage : lhcr_pkg

// >>> core/lhcr_top.sv
// Fallback-mode configuration registers and channel control
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - Phase bit 0 offsets the internal pulse trains half a period; 1 aligns.
// - Reference-select 0 uses internal current settings; 1 uses 10-bit external code.
// - Channel 2 full-duty bit forces continuous on, else follows dimming command.
// - Channel 1 full-duty bit forces continuous on, else follows dimming command.
// - Channel 2 dims from external input at 0, internal generator at 1.
// - Channel 1 dims from external input at 0, internal generator at 1.
// - Channel 2 enabled in fallback mode when its enable bit is 1.
// - Channel 1 enabled in fallback mode when its enable bit is 1.
// - Timer field selects 3.6, 7.2, 14.4 or 28.8 ms overcurrent limit.
// - Channel 2 thermal: auto-restart by hysteresis, or latch off clearing enable.
// - Channel 2 high-side limit: restart after timer, or latch off.
// - Channel 2 low-side limit: restart after timer, or latch off.
// - Channel 1 thermal: auto-restart by hysteresis, or latch off clearing enable.
// - Channel 1 high-side limit: restart after timer, or latch off.
// - Channel 1 low-side limit: restart after timer, or latch off.
// - External reference low register is read-only, two LSBs, upper bits zero.
// - Both configuration registers reset to all zeros.
// - External reference high register is read-only, eight MSBs.
// - Configuration acts only in fallback mode, except reference-select, which steers the current settings in any mode; host reads and writes it.
module lhcr_top #(
  parameter int FAULT_BASE_CYCLES = lhcr_pkg::FAULT_TIMER_BASE_CYCLES
) (
  input wire logic I_REF_CLK,
  input wire logic I_SYS_RST,
  input wire logic I_CLK_EN,
  input wire logic I_FALLBACK_MODE,
  input wire logic [7:0] I_REG_ADDR,
  input wire logic I_REG_WR,
  input wire logic [7:0] I_REG_WDATA,
  input wire logic I_REG_RD,
  output logic [7:0] O_REG_RDATA,
  input wire logic [9:0] I_EXT_REF_CODE,
  input wire logic I_EXT_REF_VALID,
  input wire logic [9:0] I_CH1_ANALOG_SETTING,
  input wire logic [9:0] I_CH2_ANALOG_SETTING,
  input wire logic [7:0] I_DIM_DIVIDER,
  input wire logic [9:0] I_CH1_DIM_WIDTH,
  input wire logic [9:0] I_CH2_DIM_WIDTH,
  input wire logic I_CH1_DIM_INPUT,
  input wire logic I_CH2_DIM_INPUT,
  input wire logic I_CH1_THERMAL_SD,
  input wire logic I_CH2_THERMAL_SD,
  input wire logic I_CH1_HS_LIMIT,
  input wire logic I_CH2_HS_LIMIT,
  input wire logic I_CH1_LS_LIMIT,
  input wire logic I_CH2_LS_LIMIT,
  output logic O_CH1_DRIVE_EN,
  output logic O_CH2_DRIVE_EN,
  output logic O_CH1_DIM,
  output logic O_CH2_DIM,
  output logic [9:0] O_CH1_CURRENT_SETTING,
  output logic [9:0] O_CH2_CURRENT_SETTING
);

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic [7:0] cfg_one_q, cfg_one_d;
  logic [7:0] cfg_two_q, cfg_two_d;
  logic [9:0] ext_ref_q, ext_ref_d;
  logic [7:0] rdata_q, rdata_d;
  logic [2:0] dim_sync_q [2];
  logic [2:0] dim_sync_d [2];
  logic [1:0] dim_ext_q, dim_ext_d;
  logic [7:0] prescale_q, prescale_d;
  logic [9:0] dim_cnt_q, dim_cnt_d;
  lhcr_pkg::lhcr_fault_e flt_q [2];
  lhcr_pkg::lhcr_fault_e flt_d [2];
  logic [lhcr_pkg::FAULT_TIMER_WIDTH-1:0] tmr_q [2];
  logic [lhcr_pkg::FAULT_TIMER_WIDTH-1:0] tmr_d [2];
  logic [1:0] drive_q, drive_d;
  logic [1:0] dim_out_q, dim_out_d;
  logic [9:0] cur1_q, cur1_d, cur2_q, cur2_d;
  logic [lhcr_pkg::FAULT_TIMER_WIDTH-1:0] timer_limit;
  logic [1:0] thermal, hs_lim, ls_lim, en_bit, full_bit, int_bit;
  logic [1:0] th_latch, hs_latch, ls_latch, latch_off, gen_dim;
  logic [9:0] cnt_ch2;

  assign thermal = {I_CH2_THERMAL_SD, I_CH1_THERMAL_SD};
  assign hs_lim = {I_CH2_HS_LIMIT, I_CH1_HS_LIMIT};
  assign ls_lim = {I_CH2_LS_LIMIT, I_CH1_LS_LIMIT};
  assign en_bit = {cfg_one_q[lhcr_pkg::BIT_CH2_ENABLE], cfg_one_q[lhcr_pkg::BIT_CH1_ENABLE]};
  assign full_bit = {cfg_one_q[lhcr_pkg::BIT_CH2_FULL_DUTY],
                     cfg_one_q[lhcr_pkg::BIT_CH1_FULL_DUTY]};
  assign int_bit = {cfg_one_q[lhcr_pkg::BIT_CH2_INT_DIM], cfg_one_q[lhcr_pkg::BIT_CH1_INT_DIM]};
  assign th_latch = {cfg_two_q[lhcr_pkg::BIT_CH2_THERMAL_LATCH],
                     cfg_two_q[lhcr_pkg::BIT_CH1_THERMAL_LATCH]};
  assign hs_latch = {cfg_two_q[lhcr_pkg::BIT_CH2_HS_OC_LATCH],
                     cfg_two_q[lhcr_pkg::BIT_CH1_HS_OC_LATCH]};
  assign ls_latch = {cfg_two_q[lhcr_pkg::BIT_CH2_LS_OC_LATCH],
                     cfg_two_q[lhcr_pkg::BIT_CH1_LS_OC_LATCH]};

  // ----------------------------------------------------------------
  // Fault timer limit, base doubled per code step
  // ----------------------------------------------------------------
  assign timer_limit = lhcr_pkg::FAULT_TIMER_WIDTH'(FAULT_BASE_CYCLES)
                       << cfg_two_q[lhcr_pkg::BIT_TIMER_LIMIT_HI:
                                    lhcr_pkg::BIT_TIMER_LIMIT_LO];

  // Latched-off faults detected this cycle, only acted on in fallback mode
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      latch_off[c] = I_FALLBACK_MODE & ((thermal[c] & th_latch[c]) | (hs_lim[c] & hs_latch[c])
                     | (ls_lim[c] & ls_latch[c]));
    end
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  always_comb begin
    cfg_one_d = cfg_one_q;
    cfg_two_d = cfg_two_q;
    ext_ref_d = ext_ref_q;
    rdata_d = rdata_q;
    if (I_REG_WR) begin
      unique case (I_REG_ADDR)
        lhcr_pkg::OFS_FALLBACK_CONFIG_ONE: cfg_one_d = I_REG_WDATA;
        lhcr_pkg::OFS_FALLBACK_CONFIG_TWO: cfg_two_d = I_REG_WDATA;
        default: ;
      endcase
    end
    // Hardware clearing wins over a host write in the same cycle
    if (latch_off[0]) begin
      cfg_one_d[lhcr_pkg::BIT_CH1_ENABLE] = 1'b0;
    end
    if (latch_off[1]) begin
      cfg_one_d[lhcr_pkg::BIT_CH2_ENABLE] = 1'b0;
    end
    if (I_EXT_REF_VALID) begin
      ext_ref_d = I_EXT_REF_CODE;
    end
    if (I_REG_RD) begin
      unique case (I_REG_ADDR)
        lhcr_pkg::OFS_FALLBACK_CONFIG_ONE: rdata_d = cfg_one_q;
        lhcr_pkg::OFS_FALLBACK_CONFIG_TWO: rdata_d = cfg_two_q;
        lhcr_pkg::OFS_EXTERNAL_REF_LOW: rdata_d = {6'h00, ext_ref_q[1:0]};
        lhcr_pkg::OFS_EXTERNAL_REF_HIGH: rdata_d = ext_ref_q[9:2];
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      cfg_one_q <= lhcr_pkg::RST_FALLBACK_CONFIG_ONE;
      cfg_two_q <= lhcr_pkg::RST_FALLBACK_CONFIG_TWO;
      ext_ref_q <= lhcr_pkg::RST_EXT_REF_CODE;
      rdata_q <= 8'h00;
    end else if (I_CLK_EN) begin
      cfg_one_q <= cfg_one_d;
      cfg_two_q <= cfg_two_d;
      ext_ref_q <= ext_ref_d;
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // External dimming inputs, three-stage synchroniser
  // ----------------------------------------------------------------
  always_comb begin
    dim_ext_d = dim_ext_q;
    dim_sync_d[0] = {dim_sync_q[0][1:0], I_CH1_DIM_INPUT};
    dim_sync_d[1] = {dim_sync_q[1][1:0], I_CH2_DIM_INPUT};
    for (int c = 0; c < 2; c++) begin
      if (dim_sync_q[c][1] == dim_sync_q[c][2]) begin
        dim_ext_d[c] = dim_sync_q[c][2];
      end
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      dim_sync_q[0] <= 3'h0;
      dim_sync_q[1] <= 3'h0;
      dim_ext_q <= 2'h0;
    end else if (I_CLK_EN) begin
      dim_sync_q[0] <= dim_sync_d[0];
      dim_sync_q[1] <= dim_sync_d[1];
      dim_ext_q <= dim_ext_d;
    end
  end

  // ----------------------------------------------------------------
  // Internal dimming generator
  // ----------------------------------------------------------------
  always_comb begin
    prescale_d = prescale_q + 8'h01;
    dim_cnt_d = dim_cnt_q;
    if (prescale_q >= I_DIM_DIVIDER) begin
      prescale_d = 8'h00;
      dim_cnt_d = dim_cnt_q + 10'h001;
    end
  end

  // Channel 2 compares against a counter shifted by half a period when the phase bit is 0, the unshifted counter when it is 1
  assign cnt_ch2 = cfg_one_q[lhcr_pkg::BIT_DIM_PHASE_SEL] ? dim_cnt_q
                   : dim_cnt_q ^ lhcr_pkg::DIM_HALF_PERIOD;
  assign gen_dim = {cnt_ch2 < I_CH2_DIM_WIDTH, dim_cnt_q < I_CH1_DIM_WIDTH};

  always_ff @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      prescale_q <= 8'h00;
      dim_cnt_q <= 10'h000;
    end else if (I_CLK_EN) begin
      prescale_q <= prescale_d;
      dim_cnt_q <= dim_cnt_d;
    end
  end

  // ----------------------------------------------------------------
  // Fault recovery per channel
  // ----------------------------------------------------------------
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      flt_d[c] = flt_q[c];
      tmr_d[c] = tmr_q[c];
      if (!I_FALLBACK_MODE) begin
        flt_d[c] = lhcr_pkg::FLT_RUN;
        tmr_d[c] = '0;
      end else if ((hs_lim[c] & ~hs_latch[c]) | (ls_lim[c] & ~ls_latch[c])) begin
        flt_d[c] = lhcr_pkg::FLT_TIMER;
        tmr_d[c] = '0;
      end else begin
        unique case (flt_q[c])
          lhcr_pkg::FLT_RUN: begin
            if (thermal[c] & ~th_latch[c]) begin
              flt_d[c] = lhcr_pkg::FLT_THERMAL;
            end
          end
          lhcr_pkg::FLT_THERMAL: begin
            if (!thermal[c]) begin
              flt_d[c] = lhcr_pkg::FLT_RUN;
            end
          end
          lhcr_pkg::FLT_TIMER: begin
            tmr_d[c] = tmr_q[c] + 1'b1;
            if (tmr_q[c] >= timer_limit - 1'b1) begin
              // Expiry while still hot hands over to the thermal wait
              flt_d[c] = (thermal[c] & ~th_latch[c]) ? lhcr_pkg::FLT_THERMAL
                         : lhcr_pkg::FLT_RUN;
              tmr_d[c] = '0;
            end
          end
          default: flt_d[c] = lhcr_pkg::FLT_RUN;
        endcase
      end
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      flt_q[0] <= lhcr_pkg::FLT_RUN;
      flt_q[1] <= lhcr_pkg::FLT_RUN;
      tmr_q[0] <= '0;
      tmr_q[1] <= '0;
    end else if (I_CLK_EN) begin
      flt_q <= flt_d;
      tmr_q <= tmr_d;
    end
  end

  // ----------------------------------------------------------------
  // Channel outputs
  // ----------------------------------------------------------------
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      drive_d[c] = I_FALLBACK_MODE & en_bit[c] & ~latch_off[c]
                   & (flt_d[c] == lhcr_pkg::FLT_RUN);
      if (full_bit[c]) begin
        dim_out_d[c] = 1'b1;
      end else if (int_bit[c]) begin
        dim_out_d[c] = gen_dim[c];
      end else begin
        dim_out_d[c] = dim_ext_q[c];
      end
      dim_out_d[c] = dim_out_d[c] & drive_d[c];
    end
    if (cfg_one_q[lhcr_pkg::BIT_EXT_REF_SEL]) begin
      cur1_d = ext_ref_q;
      cur2_d = ext_ref_q;
    end else begin
      cur1_d = I_CH1_ANALOG_SETTING;
      cur2_d = I_CH2_ANALOG_SETTING;
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      drive_q <= 2'h0;
      dim_out_q <= 2'h0;
      cur1_q <= 10'h000;
      cur2_q <= 10'h000;
    end else if (I_CLK_EN) begin
      drive_q <= drive_d;
      dim_out_q <= dim_out_d;
      cur1_q <= cur1_d;
      cur2_q <= cur2_d;
    end
  end

  assign O_REG_RDATA = rdata_q;
  assign O_CH1_DRIVE_EN = drive_q[0];
  assign O_CH2_DRIVE_EN = drive_q[1];
  assign O_CH1_DIM = dim_out_q[0];
  assign O_CH2_DIM = dim_out_q[1];
  assign O_CH1_CURRENT_SETTING = cur1_q;
  assign O_CH2_CURRENT_SETTING = cur2_q;

endmodule : lhcr_top
`default_nettype wire

// >>> verif/lhcr_asserts.sv
// Port-level assertion checker for the fallback register slice
`timescale 1ns/10ps
`default_nettype none
module lhcr_asserts (
  input wire logic I_REF_CLK,
  input wire logic I_SYS_RST,
  input wire logic I_CLK_EN,
  input wire logic I_FALLBACK_MODE,
  input wire logic [7:0] I_REG_ADDR,
  input wire logic I_REG_WR,
  input wire logic [7:0] I_REG_WDATA,
  input wire logic I_REG_RD,
  input wire logic [7:0] O_REG_RDATA,
  input wire logic [9:0] I_EXT_REF_CODE,
  input wire logic I_EXT_REF_VALID,
  input wire logic [9:0] I_CH1_ANALOG_SETTING,
  input wire logic I_CH1_THERMAL_SD,
  input wire logic I_CH2_THERMAL_SD,
  input wire logic I_CH1_HS_LIMIT,
  input wire logic I_CH2_HS_LIMIT,
  input wire logic I_CH1_LS_LIMIT,
  input wire logic I_CH2_LS_LIMIT,
  input wire logic O_CH1_DRIVE_EN,
  input wire logic O_CH2_DRIVE_EN,
  input wire logic [9:0] O_CH1_CURRENT_SETTING
);
  logic [7:0] cfg2_q, cfg2_d, ref_lo, ref_hi;
  logic [9:0] code_q, code_d, exp_cur;
  logic sel_q, sel_d;
  // ----------------------------------------------------------------
  // Shadow of host-written fields and of the external reference code
  // ----------------------------------------------------------------
  always_comb begin
    cfg2_d = cfg2_q;
    sel_d = sel_q;
    code_d = code_q;
    if (I_CLK_EN && I_REG_WR && I_REG_ADDR == 8'h1F) begin
      cfg2_d = I_REG_WDATA;
    end
    if (I_CLK_EN && I_REG_WR && I_REG_ADDR == 8'h1E) begin
      sel_d = I_REG_WDATA[6];
    end
    if (I_CLK_EN && I_EXT_REF_VALID) begin
      code_d = I_EXT_REF_CODE;
    end
    exp_cur = sel_q ? code_q : I_CH1_ANALOG_SETTING;
    ref_lo = {6'h00, code_q[1:0]};
    ref_hi = code_q[9:2];
  end
  always_ff @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      cfg2_q <= 8'h00;
      sel_q <= 1'b0;
      code_q <= 10'h000;
    end else begin
      cfg2_q <= cfg2_d;
      sel_q <= sel_d;
      code_q <= code_d;
    end
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (I_SYS_RST || !I_CLK_EN);
  AST_NO_FALLBACK: assert property (
    !I_FALLBACK_MODE |=> !O_CH1_DRIVE_EN && !O_CH2_DRIVE_EN)
    else $error("channel driven outside fallback");
  AST_OC_CH1: assert property (
    I_FALLBACK_MODE && (I_CH1_HS_LIMIT || I_CH1_LS_LIMIT) |=> !O_CH1_DRIVE_EN)
    else $error("channel 1 on after limit event");
  AST_OC_CH2: assert property (
    I_FALLBACK_MODE && (I_CH2_HS_LIMIT || I_CH2_LS_LIMIT) |=> !O_CH2_DRIVE_EN)
    else $error("channel 2 on after limit event");
  AST_TH_CH1: assert property (
    I_FALLBACK_MODE && I_CH1_THERMAL_SD |=> !O_CH1_DRIVE_EN)
    else $error("channel 1 on while hot");
  AST_TH_CH2: assert property (
    I_FALLBACK_MODE && I_CH2_THERMAL_SD |=> !O_CH2_DRIVE_EN)
    else $error("channel 2 on while hot");
  AST_RD_REF_LO: assert property (
    I_REG_RD && I_REG_ADDR == 8'h20 |=> O_REG_RDATA == $past(ref_lo))
    else $error("reference low byte wrong");
  AST_RD_REF_HI: assert property (
    I_REG_RD && I_REG_ADDR == 8'h21 |=> O_REG_RDATA == $past(ref_hi))
    else $error("reference high byte wrong");
  AST_RD_CFG2: assert property (
    I_REG_RD && I_REG_ADDR == 8'h1F |=> O_REG_RDATA == $past(cfg2_q))
    else $error("second config read wrong");
  AST_RD_HOLD: assert property (
    !I_REG_RD |=> $stable(O_REG_RDATA))
    else $error("read data moved without read");
  AST_CUR_SEL: assert property (
    I_FALLBACK_MODE |=> O_CH1_CURRENT_SETTING == $past(exp_cur))
    else $error("current reference selection wrong");
endmodule : lhcr_asserts
bind lhcr_top lhcr_asserts i_lhcr_asserts (.*);
`default_nettype wire

// >>> verif/lhcr_host.sv
// Host controller model driving the register strobe port
`timescale 1ns/10ps
`default_nettype none
module lhcr_host (
  input wire logic clk,
  input wire logic [7:0] rdata,
  output logic [7:0] addr,
  output logic wr,
  output logic [7:0] wdata,
  output logic rd
);
  initial begin
    addr = 8'h00;
    wr = 1'b0;
    wdata = 8'h00;
    rd = 1'b0;
  end
  // Released lines show inverted data so stale values are not trusted
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    addr = ~a;
    wdata = ~d;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    addr = ~a;
    d = rdata;
  endtask : rd_reg
endmodule : lhcr_host
`default_nettype wire

// >>> verif/lhcr_top_test.sv
// Self-checking bench for the fallback register slice
`timescale 1ns/10ps
`default_nettype none
module lhcr_top_test;
  logic clk, rst, fb, wr, rd, vld, d1, d2, en1, en2, dm1, dm2;
  logic [7:0] addr, wdata, rdata, v;
  logic [9:0] code, a1, a2, cur1, cur2, w1, w2;
  logic [5:0] flt;
  int n_fail, n_checks;
  lhcr_host i_lhcr_host (.clk(clk), .rdata(rdata), .addr(addr), .wr(wr), .wdata(wdata),
    .rd(rd));
  lhcr_top #(.FAULT_BASE_CYCLES(8)) i_lhcr_top (.I_REF_CLK(clk), .I_SYS_RST(rst),
    .I_CLK_EN(1'b1), .I_FALLBACK_MODE(fb), .I_REG_ADDR(addr), .I_REG_WR(wr),
    .I_REG_WDATA(wdata), .I_REG_RD(rd), .O_REG_RDATA(rdata), .I_EXT_REF_CODE(code),
    .I_EXT_REF_VALID(vld), .I_CH1_ANALOG_SETTING(a1), .I_CH2_ANALOG_SETTING(a2),
    .I_DIM_DIVIDER(8'h00), .I_CH1_DIM_WIDTH(w1), .I_CH2_DIM_WIDTH(w2),
    .I_CH1_DIM_INPUT(d1), .I_CH2_DIM_INPUT(d2), .I_CH1_THERMAL_SD(flt[2]),
    .I_CH2_THERMAL_SD(flt[5]), .I_CH1_HS_LIMIT(flt[1]), .I_CH2_HS_LIMIT(flt[4]),
    .I_CH1_LS_LIMIT(flt[0]), .I_CH2_LS_LIMIT(flt[3]), .O_CH1_DRIVE_EN(en1),
    .O_CH2_DRIVE_EN(en2), .O_CH1_DIM(dm1), .O_CH2_DIM(dm2),
    .O_CH1_CURRENT_SETTING(cur1), .O_CH2_CURRENT_SETTING(cur2));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
    n_checks++;
    if (g !== e) begin
      $display("BAD %s exp %h got %h", nm, e, g);
      n_fail++;
    end
  endtask : chk
  task automatic stop_test;
    if (n_fail == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    i_lhcr_host.rd_reg(a, v);
    chk("rdata", {2'b00, e}, {2'b00, v});
  endtask : rdc
  task automatic wrc(input logic [7:0] a, input logic [7:0] d);
    i_lhcr_host.wr_reg(a, d);
    cyc(2);
  endtask : wrc
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    rdc(8'h1E, 8'h00);
    rdc(8'h1F, 8'h00);
    rdc(8'h30, 8'h00);
    wrc(8'h1F, 8'hA5);
    rdc(8'h1F, 8'hA5);
    wrc(8'h20, 8'hFF);
    rdc(8'h20, 8'h00);
    wrc(8'h1F, 8'h00);
    code = 10'h2D7;
    vld = 1'b1;
    cyc(1);
    vld = 1'b0;
    rdc(8'h20, 8'h03);
    rdc(8'h21, 8'hB5);
    wrc(8'h1E, 8'h40);
    chk("cur1", 10'h2D7, cur1);
    chk("cur2", 10'h2D7, cur2);
    wrc(8'h1E, 8'h00);
    chk("cur1", a1, cur1);
    chk("cur2", a2, cur2);
  endtask : t_regs
  task automatic t_enable;
    wrc(8'h1E, 8'h09);
    chk("en", 10'h003, {8'h00, en2, en1});
    wrc(8'h1E, 8'h08);
    chk("en", 10'h002, {8'h00, en2, en1});
    fb = 1'b0;
    cyc(2);
    chk("en", 10'h000, {8'h00, en2, en1});
    fb = 1'b1;
    wrc(8'h1E, 8'h2D);
    chk("dim", 10'h003, {8'h00, dm2, dm1});
    wrc(8'h1E, 8'h09);
    chk("dim", 10'h000, {8'h00, dm2, dm1});
    d1 = 1'b1;
    cyc(6);
    chk("dim", 10'h001, {8'h00, dm2, dm1});
    d2 = 1'b1;
    cyc(6);
    chk("dim", 10'h003, {8'h00, dm2, dm1});
  endtask : t_enable
  task automatic t_phase(input logic [7:0] cfg, input logic same);
    wrc(8'h1E, cfg);
    repeat (8) begin
      cyc(131);
      chk("phase", {9'h000, same}, {9'h000, dm1 ~^ dm2});
    end
  endtask : t_phase
  task automatic t_width;
    wrc(8'h1E, 8'h1B);
    for (int c = 0; c < 2; c++) begin
      // A zero width must hold its own channel dark
      w1 = (c == 0) ? 10'h000 : 10'h200;
      w2 = (c == 0) ? 10'h200 : 10'h000;
      repeat (4) begin
        cyc(131);
        chk("dim_off", 10'h000, {9'h000, (c == 0) ? dm1 : dm2});
      end
    end
    w2 = 10'h200;
  endtask : t_width
  task automatic t_latch;
    for (int i = 0; i < 6; i++) begin
      wrc(8'h1F, 8'h01 << i);
      wrc(8'h1E, 8'h09);
      flt[i] = 1'b1;
      cyc(1);
      flt = 6'h00;
      cyc(1);
      rdc(8'h1E, (i < 3) ? 8'h08 : 8'h01);
    end
  endtask : t_latch
  task automatic t_timer;
    int n;
    int k;
    int lim;
    for (int c = 0; c < 4; c++) begin
      // Each timer code against a different auto-restart limit input
      k = (c < 2) ? 1 - c : 6 - c;
      lim = 8 << c;
      wrc(8'h1F, 8'(c << 6));
      wrc(8'h1E, 8'h09);
      flt[k] = 1'b1;
      cyc(1);
      flt = 6'h00;
      n = 0;
      while (((k < 3) ? !en1 : !en2) && n < 600) begin
        cyc(1);
        n++;
      end
      chk("off_time", 10'h001, {9'h000, n >= lim && n <= lim + 2});
    end
    flt[5] = 1'b1;
    cyc(3);
    chk("en2", 10'h000, {9'h000, en2});
    flt = 6'h00;
    cyc(3);
    chk("en2", 10'h001, {9'h000, en2});
  endtask : t_timer
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    stop_test();
  end
  initial begin
    rst = 1'b1;
    fb = 1'b1;
    vld = 1'b0;
    d1 = 1'b0;
    d2 = 1'b0;
    code = 10'h000;
    a1 = 10'h155;
    a2 = 10'h2AA;
    w1 = 10'h200;
    w2 = 10'h200;
    flt = 6'h00;
    n_fail = 0;
    n_checks = 0;
    cyc(5);
    rst = 1'b0;
    t_regs();
    t_enable();
    t_phase(8'h1B, 1'b0);
    t_phase(8'h9B, 1'b1);
    t_width();
    t_latch();
    t_timer();
    stop_test();
  end
endmodule : lhcr_top_test
`default_nettype wire
